// File: hw/interrupt_vector_resolver.v
// Interrupt vector resolver: finds the vector slot of an acknowledged
// request, fetches its four bytes and hands the routine address to the PC.
// Assumes a byte-wide vector memory with one cycle read latency and a
// sequencer that holds no second request while busy.
`timescale 1ns/1ps
`include "vector_resolver_defs.vh"
module interrupt_vector_resolver #(
    parameter PC_W = 20,
    parameter AW = 16
) (
    input wire i_sys_clk,
    input wire i_rst_n,
    input wire i_ack,
    input wire [3:0] i_src_kind,
    input wire i_sw_int,
    input wire [5:0] i_int_num,
    input wire [AW-1:0] i_vector_base_register,
    input wire [7:0] i_mem_data,
    output reg o_mem_rd,
    output reg [AW-1:0] o_mem_addr,
    output reg o_busy,
    output reg o_pc_load,
    output reg [PC_W-1:0] o_pc,
    output reg o_hw_num_err
);
    localparam S_IDLE = 3'h0;
    localparam S_TEST = 3'h1;
    localparam S_TWAIT = 3'h2;
    localparam S_FETCH = 3'h3;
    localparam S_DONE = 3'h4;

    reg [2:0] state_r;
    reg [2:0] state_nxt;
    reg [AW-1:0] slot_r;
    reg [AW-1:0] slot_nxt;
    reg [AW-1:0] reloc_zero_r;
    reg [AW-1:0] reloc_zero_nxt;
    reg [1:0] idx_r;
    reg [1:0] idx_nxt;
    reg [1:0] rcv_r;
    reg [1:0] rcv_nxt;
    reg [31:0] vec_r;
    reg [31:0] vec_nxt;
    reg req;
    reg [AW-1:0] req_addr;
    // Last byte request goes out once; replies arrive well after it
    reg last_sent_r;
    reg pc_load_nxt;
    reg err_nxt;
    wire port_valid;
    wire [7:0] port_data;
    wire port_rd;
    wire [AW-1:0] port_addr;

    // Fixed slot base for each non-relocatable source kind
    function [AW-1:0] fixed_base;
        input [3:0] kind;
        begin
            case (kind)
                `SRC_UND: fixed_base = `FIX_UND_BASE;
                `SRC_OVF: fixed_base = `FIX_OVF_BASE;
                `SRC_BRK: fixed_base = `FIX_BRK_BASE;
                `SRC_AMATCH: fixed_base = `FIX_AMATCH_BASE;
                `SRC_STEP: fixed_base = `FIX_STEP_BASE;
                `SRC_SPECIAL: fixed_base = `FIX_SPECIAL_BASE;
                `SRC_ABREAK: fixed_base = `FIX_ABREAK_BASE;
                `SRC_RESET: fixed_base = `FIX_RESET_BASE;
                default: fixed_base = `FIX_RSVD_BASE;
            endcase
        end
    endfunction

    // Slot address inside the relocatable table; wraps past base on purpose
    function [AW-1:0] reloc_slot;
        input [AW-1:0] base;
        input [5:0] num;
        begin
            reloc_slot = base + {{(AW-8){1'b0}}, num, 2'b00};
        end
    endfunction

    // Numbers that some hardware source owns
    function hw_owned;
        input [5:0] num;
        begin
            case (num)
                `NUM_CMP1, `NUM_CMP2: hw_owned = 1'b1;
                `NUM_CLK_TIMER: hw_owned = 1'b1;
                `NUM_SC2_TX, `NUM_SC2_RX: hw_owned = 1'b1;
                `NUM_KEY: hw_owned = 1'b1;
                `NUM_SC0_TX, `NUM_SC0_RX: hw_owned = 1'b1;
                `NUM_GTIMER1, `NUM_GTIMER2: hw_owned = 1'b1;
                `NUM_EXT_PIN2, `NUM_EXT_PIN1: hw_owned = 1'b1;
                `NUM_EXT_PIN0, `NUM_EXT_PIN4: hw_owned = 1'b1;
                `NUM_CAP_CMP1, `NUM_CAP_OVF: hw_owned = 1'b1;
                `NUM_CAP_CMP0, `NUM_CAPTURE: hw_owned = 1'b1;
                default: hw_owned = 1'b0;
            endcase
        end
    endfunction

    vector_byte_port #(
        .AW(AW)
    ) u_port (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_req(req),
        .i_addr(req_addr),
        .i_mem_data(i_mem_data),
        .o_mem_rd(port_rd),
        .o_mem_addr(port_addr),
        .o_valid(port_valid),
        .o_data(port_data)
    );

    always @* begin
        state_nxt = state_r;
        slot_nxt = slot_r;
        reloc_zero_nxt = reloc_zero_r;
        idx_nxt = idx_r;
        rcv_nxt = rcv_r;
        vec_nxt = vec_r;
        req = 1'b0;
        req_addr = slot_r;
        pc_load_nxt = 1'b0;
        err_nxt = 1'b0;
        case (state_r)
            S_IDLE: begin
                if (i_ack) begin
                    idx_nxt = 2'b00;
                    rcv_nxt = 2'b00;
                    reloc_zero_nxt = reloc_slot(i_vector_base_register,
                        `NUM_BRK);
                    if (i_sw_int || i_src_kind == `SRC_RELOC) begin
                        // Any number 0..63 from an instruction is fetched
                        slot_nxt = reloc_slot(i_vector_base_register,
                            i_int_num);
                        err_nxt = !i_sw_int && !hw_owned(i_int_num);
                        state_nxt = S_FETCH;
                    end else if (i_src_kind == `SRC_BRK) begin
                        slot_nxt = fixed_base(i_src_kind);
                        state_nxt = S_TEST;
                    end else begin
                        slot_nxt = fixed_base(i_src_kind);
                        state_nxt = S_FETCH;
                    end
                end
            end
            S_TEST: begin
                req = 1'b1;
                req_addr = `FIX_BRK_TEST;
                state_nxt = S_TWAIT;
            end
            S_TWAIT: begin
                if (port_valid) begin
                    if (port_data == `BRK_REDIRECT_BYTE) begin
                        slot_nxt = reloc_zero_r;
                    end
                    state_nxt = S_FETCH;
                end
            end
            S_FETCH: begin
                // Issue one byte per cycle, gather them as they return
                req = (idx_r != 2'b11) || !last_sent_r;
                req_addr = slot_r + {{(AW-2){1'b0}}, idx_r};
                if (req && idx_r != 2'b11) begin
                    idx_nxt = idx_r + 2'b01;
                end
                if (port_valid) begin
                    vec_nxt[rcv_r*8 +: 8] = port_data;
                    rcv_nxt = rcv_r + 2'b01;
                    if (rcv_r == 2'b11) begin
                        state_nxt = S_DONE;
                    end
                end
            end
            S_DONE: begin
                pc_load_nxt = 1'b1;
                state_nxt = S_IDLE;
            end
            default: state_nxt = S_IDLE;
        endcase
    end

    always @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_r <= S_IDLE;
            slot_r <= {AW{1'b0}};
            reloc_zero_r <= {AW{1'b0}};
            idx_r <= 2'b00;
            rcv_r <= 2'b00;
            vec_r <= 32'h0000_0000;
            last_sent_r <= 1'b0;
            o_busy <= 1'b0;
            o_pc_load <= 1'b0;
            o_pc <= {PC_W{1'b0}};
            o_hw_num_err <= 1'b0;
            o_mem_rd <= 1'b0;
            o_mem_addr <= {AW{1'b0}};
        end else begin
            state_r <= state_nxt;
            slot_r <= slot_nxt;
            reloc_zero_r <= reloc_zero_nxt;
            idx_r <= idx_nxt;
            rcv_r <= rcv_nxt;
            vec_r <= vec_nxt;
            o_hw_num_err <= err_nxt;
            o_busy <= (state_nxt != S_IDLE);
            o_mem_rd <= port_rd;
            o_mem_addr <= port_addr;
            if (state_r == S_FETCH && req && idx_r == 2'b11) begin
                last_sent_r <= 1'b1;
            end else if (state_r != S_FETCH) begin
                last_sent_r <= 1'b0;
            end
            o_pc_load <= pc_load_nxt;
            if (pc_load_nxt) begin
                // Upper vector bits beyond the PC width are dropped
                o_pc <= vec_r[PC_W-1:0];
            end
        end
    end
endmodule // interrupt_vector_resolver

// File: hw/vector_resolver_defs.vh
// Constants for the interrupt vector resolver: table layout and source codes.
// Included by the resolver only; its byte-wide memory port module does not include it.
`ifndef VECTOR_RESOLVER_DEFS_VH
`define VECTOR_RESOLVER_DEFS_VH

`define VEC_BYTES 3'h4
`define FIX_UND_BASE 16'hffdc
`define FIX_OVF_BASE 16'hffe0
`define FIX_BRK_BASE 16'hffe4
`define FIX_BRK_TEST 16'hffe7
`define FIX_AMATCH_BASE 16'hffe8
`define FIX_STEP_BASE 16'hffec
`define FIX_SPECIAL_BASE 16'hfff0
`define FIX_ABREAK_BASE 16'hfff4
`define FIX_RSVD_BASE 16'hfff8
`define FIX_RESET_BASE 16'hfffc
`define BRK_REDIRECT_BYTE 8'hff

// Source kinds presented with a request
`define SRC_UND 4'h0
`define SRC_OVF 4'h1
`define SRC_BRK 4'h2
`define SRC_AMATCH 4'h3
`define SRC_STEP 4'h4
`define SRC_SPECIAL 4'h5
`define SRC_ABREAK 4'h6
`define SRC_RESET 4'h7
`define SRC_RELOC 4'h8

// Relocatable interrupt numbers: BRK, hardware sources, first software number
`define NUM_BRK 6'h00
`define NUM_CMP1 6'h01
`define NUM_CMP2 6'h02
`define NUM_CLK_TIMER 6'h0a
`define NUM_SC2_TX 6'h0b
`define NUM_SC2_RX 6'h0c
`define NUM_KEY 6'h0d
`define NUM_CAP_CMP1 6'h10
`define NUM_SC0_TX 6'h11
`define NUM_SC0_RX 6'h12
`define NUM_EXT_PIN2 6'h15
`define NUM_GTIMER1 6'h16
`define NUM_GTIMER2 6'h18
`define NUM_EXT_PIN1 6'h19
`define NUM_CAP_OVF 6'h1b
`define NUM_CAP_CMP0 6'h1c
`define NUM_EXT_PIN0 6'h1d
`define NUM_EXT_PIN4 6'h1e
`define NUM_CAPTURE 6'h1f
`define NUM_SW_FIRST 6'h20

`endif

// File: hw/vector_byte_port.v
// Byte read port towards the vector memory, with a registered data return.
// Assumes memory answers one cycle after the strobe that the resolver
// re-registers onto its own pins, two cycles after o_mem_rd here.
`timescale 1ns/1ps
module vector_byte_port #(
    parameter AW = 16
) (
    input wire i_sys_clk,
    input wire i_rst_n,
    input wire i_req,
    input wire [AW-1:0] i_addr,
    input wire [7:0] i_mem_data,
    output reg o_mem_rd,
    output reg [AW-1:0] o_mem_addr,
    output reg o_valid,
    output reg [7:0] o_data
);
    reg pend_r;
    reg land_r;

    // Read data is registered so the resolver never sees a raw memory path
    always @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_mem_rd <= 1'b0;
            o_mem_addr <= {AW{1'b0}};
            pend_r <= 1'b0;
            land_r <= 1'b0;
            o_valid <= 1'b0;
            o_data <= 8'h00;
        end else begin
            o_mem_rd <= i_req;
            if (i_req) begin
                o_mem_addr <= i_addr;
            end
            // Pend mirrors the pin strobe, land the cycle memory drives data
            pend_r <= o_mem_rd;
            land_r <= pend_r;
            o_valid <= land_r;
            if (land_r) begin
                o_data <= i_mem_data;
            end
        end
    end
endmodule // vector_byte_port

// File: testbench/vector_mem_model.sv
// Vector memory model: one byte per strobe, answered on the next cycle.
// Assumes a 16-bit byte address from the resolver.
`timescale 1ns/1ps
module vector_mem_model (
    input wire i_sys_clk,
    input wire i_mem_rd,
    input wire [15:0] i_mem_addr,
    input wire i_brk_redirect,
    output reg [7:0] o_data
);
    // Idle bus toggles so a stale byte never passes for data
    initial o_data = 8'h00;
    always @(posedge i_sys_clk) begin
        if (!i_mem_rd) o_data <= ~o_data;
        else if (i_brk_redirect && i_mem_addr == 16'hffe7)
            o_data <= 8'hff;
        else
            o_data <= i_mem_addr[7:0] ^ i_mem_addr[15:8] ^ 8'h3c;
    end
endmodule // vector_mem_model

// File: testbench/vector_resolver_sva.sv
// Checker for the vector resolver ports: slot fetch and PC hand-over.
// Assumes the bench holds base and number steady during a fetch.
`timescale 1ns/1ps
module vector_resolver_checker #(
    parameter PC_W = 20,
    parameter AW = 16
) (
    input wire i_sys_clk,
    input wire i_rst_n,
    input wire i_ack,
    input wire [3:0] i_src_kind,
    input wire [5:0] i_int_num,
    input wire [AW-1:0] i_vector_base_register,
    input wire o_mem_rd,
    input wire [AW-1:0] o_mem_addr,
    input wire o_busy,
    input wire o_pc_load,
    input wire [PC_W-1:0] o_pc
);
    wire take = i_ack && !o_busy;
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    property p_take; take |=> o_busy; endproperty
    a_take: assert property (p_take) else $error("No busy");
    property p_answer; $rose(o_busy) |-> ##[1:16] o_pc_load; endproperty
    a_answer: assert property (p_answer) else $error("No load");
    property p_pulse; o_pc_load |=> !o_pc_load; endproperty
    a_pulse: assert property (p_pulse) else $error("Long load");
    property p_hold; !o_pc_load |-> $stable(o_pc); endproperty
    a_hold: assert property (p_hold) else $error("PC moved");
    property p_step; o_mem_rd && $past(o_mem_rd) && $past(o_mem_addr) !=
        16'hffe7 |-> o_mem_addr == $past(o_mem_addr) + 1'b1; endproperty
    a_step: assert property (p_step) else $error("Byte order");
    property p_fixed; take && i_src_kind == 4'h7
        |-> ##[1:8] o_mem_rd && o_mem_addr == 16'hfffc; endproperty
    a_fixed: assert property (p_fixed) else $error("Reset slot");
    property p_brk; take && i_src_kind == 4'h2
        |-> ##[1:8] o_mem_rd && o_mem_addr == 16'hffe7; endproperty
    a_brk: assert property (p_brk) else $error("No probe");
    property p_reloc; take && i_src_kind == 4'h8 |-> ##[1:8] o_mem_rd &&
        o_mem_addr == i_vector_base_register + {i_int_num, 2'b00};
    endproperty
    a_reloc: assert property (p_reloc) else $error("Reloc slot");
endmodule // vector_resolver_checker

bind interrupt_vector_resolver vector_resolver_checker #(.PC_W(PC_W),
    .AW(AW)) u_vector_resolver_checker (.i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n), .i_ack(i_ack), .i_src_kind(i_src_kind),
    .i_int_num(i_int_num), .i_vector_base_register(i_vector_base_register),
    .o_mem_rd(o_mem_rd), .o_mem_addr(o_mem_addr), .o_busy(o_busy),
    .o_pc_load(o_pc_load), .o_pc(o_pc));

// File: testbench/interrupt_vector_resolver_tb.sv
// Bench for the vector resolver: table rows, then brk, reset, unowned-number error flag.
// Assumes the memory model answers each strobe one cycle later.
`timescale 1ns/1ps
`define CHK(n, e, s) begin total_checks = total_checks + 1; \
    if ((s) !== (e)) begin err_total = err_total + 1; \
    $display("Error %s exp %h got %h", n, e, s); end end
module interrupt_vector_resolver_tb;
    reg i_sys_clk = 1'b0, i_rst_n = 1'b0, i_ack = 1'b0, i_sw_int = 1'b0;
    reg brk_redirect = 1'b0, seen_err = 1'b0;
    reg [3:0] i_src_kind = 4'h0;
    reg [5:0] i_int_num = 6'h00;
    reg [15:0] i_vector_base_register = 16'h1230;
    reg [18:0] rows [0:29];
    wire [7:0] mem_data;
    wire o_mem_rd, o_busy, o_pc_load, o_hw_num_err;
    wire [15:0] o_mem_addr;
    wire [19:0] o_pc;
    integer err_total = 0, total_checks = 0, cycles = 0, i, t;
    interrupt_vector_resolver u_interrupt_vector_resolver (
        .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_ack(i_ack),
        .i_src_kind(i_src_kind), .i_sw_int(i_sw_int), .i_int_num(i_int_num),
        .i_vector_base_register(i_vector_base_register),
        .i_mem_data(mem_data), .o_mem_rd(o_mem_rd), .o_mem_addr(o_mem_addr),
        .o_busy(o_busy), .o_pc_load(o_pc_load), .o_pc(o_pc),
        .o_hw_num_err(o_hw_num_err));
    vector_mem_model u_vector_mem_model (.i_sys_clk(i_sys_clk),
        .i_mem_rd(o_mem_rd), .i_mem_addr(o_mem_addr),
        .i_brk_redirect(brk_redirect), .o_data(mem_data));
    function [18:0] r(input integer k, s, n, o);
        r = {k[3:0], s[0], n[5:0], o[7:0]};
    endfunction
    // Only the low four bits of the third byte fit a 20-bit PC
    function [19:0] pc_of(input [15:0] a);
        reg [15:0] a1, a2;
        begin
            a1 = a + 16'h1;
            a2 = a + 16'h2;
            pc_of = {a2[3:0] ^ a2[11:8] ^ 4'hc, a1[7:0] ^ a1[15:8] ^ 8'h3c,
                a[7:0] ^ a[15:8] ^ 8'h3c};
        end
    endfunction
    initial forever #4 i_sys_clk = ~i_sys_clk;
    // Sampled at the falling edge, away from the edge that moves outputs
    always @(negedge i_sys_clk) begin
        cycles = cycles + 1;
        if (o_hw_num_err === 1'b1) seen_err = 1'b1;
        if (cycles == 5000) begin
            err_total = err_total + 1;
            tally_and_finish;
        end
    end
    task req(input [3:0] k, input s, input [5:0] n, input [15:0] slot,
        input e, input dup);
        begin
            while (o_busy !== 1'b0) @(negedge i_sys_clk);
            {i_ack, i_src_kind, i_sw_int, i_int_num} = {1'b1, k, s, n};
            seen_err = 1'b0;
            @(negedge i_sys_clk) i_ack = 1'b0;
            if (dup) begin
                // A second accept while busy must be ignored
                @(negedge i_sys_clk) {i_ack, i_src_kind} = 5'h10;
                @(negedge i_sys_clk) i_ack = 1'b0;
            end
            for (t = 0; t < 40 && o_pc_load !== 1'b1; t = t + 1)
                @(negedge i_sys_clk);
            `CHK("pc", pc_of(slot), o_pc)
            repeat (2) @(negedge i_sys_clk);
            `CHK("num_err", e, seen_err)
        end
    endtask
    task tally_and_finish;
        begin
            $display("Checks %0d errors %0d", total_checks, err_total);
            if (err_total == 0 && total_checks > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask
    initial begin
        // Kinds 4 and 6 stand in for a debugger, never for software
        rows = '{r(0,0,0,220), r(1,0,0,224), r(3,0,0,232), r(4,0,0,236),
            r(5,0,0,240), r(6,0,0,244), r(9,0,0,248), r(7,0,0,252),
            r(8,0,1,4), r(8,0,2,8), r(8,0,10,40), r(8,0,11,44),
            r(8,0,12,48), r(8,0,13,52), r(8,0,16,64), r(8,0,17,68),
            r(8,0,18,72), r(8,0,21,84), r(8,0,22,88), r(8,0,24,96),
            r(8,0,25,100), r(8,0,27,108), r(8,0,28,112), r(8,0,29,116),
            r(8,0,30,120), r(8,0,31,124), r(8,1,0,0), r(8,1,5,20),
            r(8,1,32,128), r(8,1,63,252)};
        repeat (20) @(negedge i_sys_clk);
        `CHK("pc_rst", 20'h00000, o_pc)
        i_rst_n = 1'b1;
        for (i = 0; i < 30; i = i + 1)
            req(rows[i][18:15], rows[i][14], rows[i][13:8],
                rows[i][18:15] == 4'h8 ? 16'h1230 + rows[i][7:0]
                : {8'hff, rows[i][7:0]}, 1'b0, 1'b0);
        req(4'h2, 1'b0, 6'h00, 16'hffe4, 1'b0, 1'b0);
        brk_redirect = 1'b1;
        req(4'h2, 1'b0, 6'h00, 16'h1230, 1'b0, 1'b0);
        req(4'h7, 1'b0, 6'h00, 16'hfffc, 1'b0, 1'b1);
        {i_ack, i_src_kind} = 5'h18;
        @(negedge i_sys_clk) i_ack = 1'b0;
        repeat (3) @(negedge i_sys_clk);
        i_rst_n = 1'b0;
        #1;
        `CHK("busy_mid", 1'b0, o_busy)
        repeat (20) @(negedge i_sys_clk);
        i_rst_n = 1'b1;
        i_vector_base_register = 16'h4002;
        req(4'h8, 1'b0, 6'h03, 16'h400e, 1'b1, 1'b0);
        req(4'h8, 1'b1, 6'h03, 16'h400e, 1'b0, 1'b0);
        tally_and_finish;
    end
endmodule // interrupt_vector_resolver_tb
